// file: design/bitstream_loader.sv
// configuration loader: flash link, slave port, apb registers, config memory
// How it works
// - full load always follows power-up reset
// - low reload pin discards and restarts load
// - three mode pins choose load method
// - serial x1 x2 x4, parallel x8 x16
// - bus width found from sync word
// - master mode reads image from flash
// - internal divided clock, or external clock
// - slave words arrive as 32-bit writes
// - failed update falls back to original image
// - keystream decrypts each data word during load
// - key from battery ram or fuses
// - running tag must match image tag
// - config memory readable while design runs
// - partial load keeps other regions running
// - dynamic reconfig port registers readable, writable
`timescale 1ns/1ns
module bitstream_loader
  import loader_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  // system
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // board pins
  input  wire logic               reloadN,
  input  wire logic [2:0]         modePins,
  // flash link
  input  wire logic               cfgClk,
  input  wire logic [15:0]        flashData,
  output logic                    flashCsN,
  output logic                    flashImageSel,
  output logic                    cclkOut,
  // keys
  input  wire logic [KEY_W-1:0]   batteryKey,
  input  wire logic [KEY_W-1:0]   fuseKey,
  // status
  output logic                    userActive,
  output logic                    loadDone,
  output logic                    loadFail,
  output logic                    fallbackUsed,
  output logic      [31:0]        drpCtrl
);
  logic              rstMeta, rstn;
  logic              rlMeta, rlSync;
  logic [2:0]        modeMeta, modeSync;
  logic              togMeta, togSync, togPrev;
  logic              csMeta, csSync;
  logic [2:0]        widthMeta, widthSync;
  load_state_e       st;
  logic              pendLoad, fbRetry, reloadReq;
  logic [2:0]        modeLat;
  logic [CFG_AW-1:0] wrAddr, rbAddr;
  logic [15:0]       remain;
  logic [31:0]       toCnt;
  logic [4:0]        ctrl;
  logic              runReq, parReq;
  logic [3:0]        divCnt;
  logic [31:0]       cfgMem [CFG_DEPTH];
  logic [31:0]       drpMem [DRP_DEPTH];
  logic [31:0]       rdata;
  logic              apbWrite, slaveMode, slaveWrite, linkPulse;
  logic              wordValid, loading, loadErr, startLoad;
  logic [31:0]       wordData;
  // link domain
  logic              linkRstMeta, linkRstn;
  logic              runMeta, runL, parMeta, parL, ceMeta, ceL;
  logic [31:0]       shiftReg  [LANES];
  logic [31:0]       nextShift [LANES];
  logic              locked, linkTog, hit;
  logic [2:0]        lane, hitLane;
  logic [5:0]        bitCnt, step, next_bitCnt;
  logic [31:0]       linkWord;

  cipher_if cif ();

  image_cipher uCipher (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .port (cif.core)
  );

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_SLAVE)
            || (a == ADDR_RBADDR) || (a == ADDR_RBDATA)
            || (a[11:5] == ADDR_DRP[11:5] && a[1:0] == 2'h0);
  endfunction : isMapped

  // reset release, then pin synchronisers
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstn    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstn    <= rstMeta;
    end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      // counts as reload held until the pin and mode straps are through
      rlMeta    <= 1'b0;
      rlSync    <= 1'b0;
      csMeta    <= 1'b1;
      csSync    <= 1'b1;
      modeMeta  <= 3'h0;
      modeSync  <= 3'h0;
      togMeta   <= 1'b0;
      togSync   <= 1'b0;
      togPrev   <= 1'b0;
      widthMeta <= 3'h0;
      widthSync <= 3'h0;
    end
    else if (ce)
    begin
      rlMeta    <= reloadN;
      rlSync    <= rlMeta;
      modeMeta  <= modePins;
      modeSync  <= modeMeta;
      togMeta   <= linkTog;
      togSync   <= togMeta;
      togPrev   <= togSync;
      widthMeta <= lane;
      widthSync <= widthMeta;
      csMeta    <= flashCsN;
      csSync    <= csMeta;
    end

  // word source: flash link in master modes, apb writes in slave mode
  assign apbWrite   = psel && penable && pwrite && pready && isMapped(paddr);
  assign slaveMode  = (modeLat == MODE_SLAVE);
  assign slaveWrite = apbWrite && (paddr == ADDR_SLAVE) && slaveMode;
  assign linkPulse  = togSync ^ togPrev;
  // linkWord is held two link cycles, longer than the toggle takes to arrive
  assign wordValid  = slaveMode ? slaveWrite : linkPulse;
  assign wordData   = slaveMode ? pwdata : linkWord;
  assign loading    = (st == ST_SYNC) || (st == ST_HEADER)
                   || (st == ST_DATA) || (st == ST_TAG);
  // a new load waits until the flash is seen released, so a cut frame always ends
  assign startLoad  = (st == ST_IDLE) && rlSync && csSync && pendLoad;
  assign loadErr    = (loading && toCnt >= 32'(TIMEOUT_CYCLES))
                   || ((st == ST_SYNC) && modeLat != MODE_SERIAL
                       && modeLat != MODE_PARALLEL && !slaveMode)
                   || ((st == ST_TAG) && wordValid && wordData != cif.mac);

  assign cif.key        = ctrl[CTRL_KEYFUSE] ? fuseKey : batteryKey;
  assign cif.start      = startLoad;
  assign cif.valid      = (st == ST_DATA) && wordValid;
  assign cif.cipherWord = wordData;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      st           <= ST_IDLE;
      pendLoad     <= 1'b1;
      fbRetry      <= 1'b0;
      modeLat      <= 3'h0;
      wrAddr       <= '0;
      remain       <= 16'h0;
      toCnt        <= 32'h0;
      flashImageSel <= 1'b0;
      userActive   <= 1'b0;
      loadDone     <= 1'b0;
      loadFail     <= 1'b0;
      fallbackUsed <= 1'b0;
    end
    else if (ce)
    begin
      toCnt <= (loading && !wordValid) ? toCnt + 32'h1 : 32'h0;
      if (!rlSync)
      begin
        st         <= ST_IDLE;
        pendLoad   <= 1'b1;
        userActive <= 1'b0;
        loadDone   <= 1'b0;
        loadFail   <= 1'b0;
      end
      else if (loadErr)
      begin
        if (ctrl[CTRL_FALLBACK] && flashImageSel)
        begin
          flashImageSel <= 1'b0;
          fbRetry       <= 1'b1;
          pendLoad      <= 1'b1;
          st            <= ST_IDLE;
        end
        else
        begin
          st         <= ST_FAIL;
          loadFail   <= 1'b1;
          userActive <= 1'b0;
        end
      end
      else
        unique case (st)
          ST_IDLE:
            if (startLoad)
            begin
              pendLoad      <= 1'b0;
              modeLat       <= modeSync;
              flashImageSel <= ctrl[CTRL_FALLBACK] && !fbRetry;
              fallbackUsed  <= fbRetry;
              fbRetry       <= 1'b0;
              loadDone      <= 1'b0;
              loadFail      <= 1'b0;
              userActive    <= userActive && ctrl[CTRL_PARTIAL];
              st            <= ST_SYNC;
            end
          ST_SYNC:
            if (wordValid && wordData == SYNC_WORD)
              st <= ST_HEADER;
          ST_HEADER:
            if (wordValid)
            begin
              remain <= wordData[HDR_LEN_LSB +: 16];
              wrAddr <= wordData[HDR_BASE_LSB +: CFG_AW];
              st     <= (wordData[HDR_LEN_LSB +: 16] == 16'h0) ? ST_TAG : ST_DATA;
            end
          ST_DATA:
            if (wordValid)
            begin
              wrAddr <= wrAddr + 6'h1;
              remain <= remain - 16'h1;
              if (remain == 16'h1)
                st <= ST_TAG;
            end
          ST_TAG:
            if (wordValid)
            begin
              st         <= ST_DONE;
              loadDone   <= 1'b1;
              userActive <= 1'b1;
            end
          ST_DONE:
            if (pendLoad)
              st <= ST_IDLE;
          ST_FAIL:
            if (pendLoad)
              st <= ST_IDLE;
          default:
            st <= ST_IDLE;
        endcase
      // a software reload request wins over the clear at load start
      if (reloadReq)
        pendLoad <= 1'b1;
    end

  // no reset on the array; words land as they decrypt
  always_ff @(posedge clk)
    if (ce && cif.valid)
      cfgMem[wrAddr] <= cif.plainWord;

  // levels handed to the link side
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      runReq  <= 1'b0;
      parReq  <= 1'b0;
      divCnt  <= 4'h0;
      cclkOut <= 1'b0;
    end
    else if (ce)
    begin
      runReq <= loading && !slaveMode && rlSync;
      parReq <= (modeLat == MODE_PARALLEL);
      if (runReq && !ctrl[CTRL_EXTCLK])
      begin
        divCnt <= (divCnt == CCLK_HALF - 4'h1) ? 4'h0 : divCnt + 4'h1;
        if (divCnt == CCLK_HALF - 4'h1)
          cclkOut <= ~cclkOut;
      end
      else
      begin
        divCnt  <= 4'h0;
        cclkOut <= 1'b0;
      end
    end

  // apb registers, no wait states
  always_comb
  begin
    rdata = 32'h0;
    if (paddr[11:5] == ADDR_DRP[11:5])
      rdata = drpMem[paddr[DRP_AW+1:2]];
    else
      unique case (paddr)
        ADDR_CTRL:   rdata = {27'h0, ctrl};
        ADDR_STATUS:
        begin
          rdata[STS_DONE]          = loadDone;
          rdata[STS_FAIL]          = loadFail;
          rdata[STS_FALLBACK]      = fallbackUsed;
          rdata[STS_ACTIVE]        = userActive;
          rdata[STS_STATE +: 3]    = st;
          rdata[STS_WIDTH +: 3]    = slaveMode ? WIDTH_SLAVE : widthSync;
          rdata[STS_MODE +: 3]     = modeLat;
        end
        ADDR_RBADDR: rdata = {26'h0, rbAddr};
        ADDR_RBDATA: rdata = cfgMem[rbAddr];
        default:     rdata = 32'h0;
      endcase
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ctrl      <= CTRL_RST;
      reloadReq <= 1'b0;
      rbAddr    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0;
      for (int i = 0; i < DRP_DEPTH; i++)
        drpMem[i] <= 32'h0;
    end
    else if (ce)
    begin
      pready    <= psel && !penable;
      reloadReq <= apbWrite && (paddr == ADDR_CTRL) && pwdata[CTRL_RELOAD];
      // error flag stands only in the access cycle
      pslverr <= psel && !penable && !isMapped(paddr);
      if (psel && !penable)
        prdata <= isMapped(paddr) ? rdata : 32'h0;
      if (apbWrite)
      begin
        if (paddr == ADDR_CTRL)
          ctrl <= {pwdata[4:1], 1'b0};
        if (paddr == ADDR_RBADDR)
          rbAddr <= pwdata[CFG_AW-1:0];
        if (paddr[11:5] == ADDR_DRP[11:5])
          drpMem[paddr[DRP_AW+1:2]] <= pwdata;
      end
    end

  assign drpCtrl = drpMem[0];

  // link side, on the configuration clock seen at the pin
  always_ff @(posedge cfgClk or negedge resetn)
    if (!resetn)
    begin
      linkRstMeta <= 1'b0;
      linkRstn    <= 1'b0;
    end
    else
    begin
      linkRstMeta <= 1'b1;
      linkRstn    <= linkRstMeta;
    end

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : gLane
      localparam int W = 1 << g;
      assign nextShift[g] = {shiftReg[g][WORD_W-1-W:0], flashData[W-1:0]};
      always_ff @(posedge cfgClk or negedge linkRstn)
        if (!linkRstn)
          shiftReg[g] <= 32'h0;
        else if (ceL)
          shiftReg[g] <= nextShift[g];
    end
  endgenerate

  // widest lane that sees the sync word wins
  always_comb
  begin
    hit     = 1'b0;
    hitLane = 3'h0;
    for (int i = 0; i < LANES; i++)
      if ((parL ? (i >= SERIAL_LANES) : (i < SERIAL_LANES))
          && nextShift[i] == SYNC_WORD)
      begin
        hit     = 1'b1;
        hitLane = 3'(i);
      end
  end

  assign step        = 6'h01 << lane;
  assign next_bitCnt = bitCnt + step;

  always_ff @(posedge cfgClk or negedge linkRstn)
    if (!linkRstn)
    begin
      runMeta  <= 1'b0;
      runL     <= 1'b0;
      parMeta  <= 1'b0;
      parL     <= 1'b0;
      ceMeta   <= 1'b0;
      ceL      <= 1'b0;
      locked   <= 1'b0;
      lane     <= 3'h0;
      bitCnt   <= 6'h0;
      linkWord <= 32'h0;
      linkTog  <= 1'b0;
      flashCsN <= 1'b1;
    end
    else
    begin
      runMeta <= runReq;
      runL    <= runMeta;
      parMeta <= parReq;
      parL    <= parMeta;
      ceMeta  <= ce;
      ceL     <= ceMeta;
      if (ceL)
      begin
        flashCsN <= !runL;
        if (!runL)
        begin
          locked <= 1'b0;
          bitCnt <= 6'h0;
        end
        else if (!locked && hit)
        begin
          locked   <= 1'b1;
          lane     <= hitLane;
          bitCnt   <= 6'h0;
          linkWord <= SYNC_WORD;
          linkTog  <= ~linkTog;
        end
        else if (locked)
        begin
          bitCnt <= (next_bitCnt == BITS_PER_WORD) ? 6'h0 : next_bitCnt;
          if (next_bitCnt == BITS_PER_WORD)
          begin
            linkWord <= nextShift[lane];
            linkTog  <= ~linkTog;
          end
        end
      end
    end
endmodule : bitstream_loader

// file: design/cipher_if.sv
// signals between the loader and its cipher core
`timescale 1ns/1ns
interface cipher_if;
  import loader_pkg::*;
  logic [KEY_W-1:0]  key;
  logic              start;
  logic              valid;
  logic [WORD_W-1:0] cipherWord;
  logic [WORD_W-1:0] plainWord;
  logic [WORD_W-1:0] mac;
  modport core (input key, start, valid, cipherWord, output plainWord, mac);
  modport ctl  (output key, start, valid, cipherWord, input plainWord, mac);
endinterface : cipher_if

// file: design/image_cipher.sv
// on-the-fly image decryption and running authentication tag
`timescale 1ns/1ns
module image_cipher
  import loader_pkg::*;
(
  // system
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // stream
  cipher_if.core    port
);
  logic [WORD_W-1:0] ks;
  logic [WORD_W-1:0] keyFold;

  // whole key folds into every step so each key bit matters
  function automatic logic [WORD_W-1:0] fold(input logic [KEY_W-1:0] k);
    fold = '0;
    for (int i = 0; i < KEY_W / WORD_W; i++)
      fold = {fold[WORD_W-2:0], fold[WORD_W-1]} ^ k[i*WORD_W +: WORD_W];
  endfunction : fold

  assign keyFold = fold(port.key);
  assign port.plainWord = port.cipherWord ^ ks;

  // light keystream core; limitation: not a full aes round engine
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ks       <= '0;
      port.mac <= '0;
    end
    else if (ce)
    begin
      if (port.start)
      begin
        ks       <= keyFold;
        port.mac <= ~keyFold;
      end
      else if (port.valid)
      begin
        ks       <= {ks[30:0], ks[31] ^ ks[21] ^ ks[1] ^ ks[0]} ^ keyFold;
        port.mac <= {port.mac[26:0], port.mac[31:27]} ^ port.plainWord ^ keyFold;
      end
    end
endmodule : image_cipher

// file: design/loader_pkg.sv
// shared constants and types for the bitstream configuration loader
package loader_pkg;
  localparam int          WORD_W        = 32;
  localparam int          KEY_W         = 256;
  localparam int          CFG_AW        = 6;
  localparam int          CFG_DEPTH     = 64;
  localparam int          DRP_AW        = 3;
  localparam int          DRP_DEPTH     = 8;
  localparam int          LANES         = 5;
  localparam int          SERIAL_LANES  = 3;
  localparam logic [31:0] SYNC_WORD     = 32'h5a3c0ff0;
  localparam logic [5:0]  BITS_PER_WORD = 6'h20;
  localparam logic [2:0]  WIDTH_SLAVE   = 3'h5;
  // mode pin codes
  localparam logic [2:0]  MODE_SERIAL   = 3'h1;
  localparam logic [2:0]  MODE_PARALLEL = 3'h2;
  localparam logic [2:0]  MODE_SLAVE    = 3'h6;
  // apb byte offsets
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_SLAVE    = 12'h008;
  localparam logic [11:0] ADDR_RBADDR   = 12'h00c;
  localparam logic [11:0] ADDR_RBDATA   = 12'h010;
  localparam logic [11:0] ADDR_DRP      = 12'h040;
  // control fields
  localparam int          CTRL_RELOAD   = 0;
  localparam int          CTRL_EXTCLK   = 1;
  localparam int          CTRL_KEYFUSE  = 2;
  localparam int          CTRL_FALLBACK = 3;
  localparam int          CTRL_PARTIAL  = 4;
  localparam logic [4:0]  CTRL_RST      = 5'h08;
  // status fields
  localparam int          STS_DONE      = 0;
  localparam int          STS_FAIL      = 1;
  localparam int          STS_FALLBACK  = 2;
  localparam int          STS_ACTIVE    = 3;
  localparam int          STS_STATE     = 4;
  localparam int          STS_WIDTH     = 8;
  localparam int          STS_MODE      = 12;
  // header word fields
  localparam int          HDR_LEN_LSB   = 0;
  localparam int          HDR_BASE_LSB  = 16;
  // timing
  localparam int          CLK_MHZ       = 250;
  localparam int          TIMEOUT_US    = 100;
  localparam int          TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
  localparam logic [3:0]  CCLK_HALF     = 4'h4;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SYNC   = 3'b001,
    ST_HEADER = 3'b010,
    ST_DATA   = 3'b011,
    ST_TAG    = 3'b100,
    ST_DONE   = 3'b101,
    ST_FAIL   = 3'b110
  } load_state_e;
endpackage : loader_pkg

// file: verification/flash_model.sv
// flash model streaming one image, msb first, on the low lanes
`timescale 1ns/1ns
module flash_model
  import loader_pkg::*;
(
  // link
  input  wire logic        cfgClk,
  input  wire logic        flashCsN,
  input  wire logic [4:0]  busW,
  output logic      [15:0] flashData
);
  logic [31:0] img [5];
  int          bitPos;
  initial
  begin
    img       = '{SYNC_WORD, 32'h0000_0002, 32'h1357_9bdf, 32'h2468_ace0, 32'h0bad_0bad};
    bitPos    = -32;
    flashData = 16'h0000;
  end
  // driven on the falling edge so the rising edge sees settled data
  always @(negedge cfgClk)
  begin
    if (flashCsN)
    begin
      bitPos    <= -32;
      flashData <= ~flashData; // released bus holds no level
    end
    else
    begin
      bitPos <= bitPos + busW;
      if (bitPos < 0 || bitPos >= 160)
        flashData <= 16'hffff;
      else
        flashData <= 16'((img[bitPos / 32] >> (32 - busW - bitPos % 32)) &
                         ((32'h1 << busW) - 32'h1));
    end
  end
endmodule : flash_model

// file: verification/loader_asserts.sv
// assertions on the loader top ports
`timescale 1ns/1ns
module loader_asserts
  import loader_pkg::*;
(
  // system
  input wire logic        clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and status
  input wire logic        reloadN,
  input wire logic        flashCsN,
  input wire logic        flashImageSel,
  input wire logic        cclkOut,
  input wire logic        loadDone,
  input wire logic        loadFail,
  input wire logic        fallbackUsed
);
  logic [7:0] lowCnt;
  logic       acc;
  logic       mapped;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  assign acc    = psel && penable && pready;
  assign mapped = paddr[1:0] == 2'b00 && ((paddr >= ADDR_DRP && paddr <= 12'h05c) ||
                  paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_SLAVE, ADDR_RBADDR, ADDR_RBDATA});
  // saturating, so a long hold of the pin stays legal
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lowCnt <= 8'h00;
    else if (reloadN)
      lowCnt <= 8'h00;
    else if (lowCnt != 8'hff)
      lowCnt <= lowCnt + 8'h01;
  end
  a_outcome_excl: assert property (!(loadDone && loadFail))
    else $error("done and fail high together");
  a_apb_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_access: assert property (pslverr |-> acc)
    else $error("error outside access");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_reload_idle: assert property (lowCnt >= 8'h3c |-> flashCsN)
    else $error("flash selected while reload held");
  a_cclk_low: assert property ($fell(cclkOut) |-> !cclkOut [*4])
    else $error("config clock low phase too short");
  a_fallback_orig: assert property (fallbackUsed |-> !flashImageSel)
    else $error("fallback not on original image");
  a_reload_clear: assert property (acc && !pwrite && paddr == ADDR_CTRL |-> !prdata[CTRL_RELOAD])
    else $error("reload bit reads back set");
endmodule : loader_asserts

bind bitstream_loader loader_asserts u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .reloadN, .flashCsN, .flashImageSel, .cclkOut, .loadDone,
  .loadFail, .fallbackUsed);

// file: verification/tb_top.sv
// testbench: loads in every width, slave load, register access
`timescale 1ns/1ns
module tb_top
  import loader_pkg::*;
;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} note_s;
  logic clk = 1'b0, cfgClk = 1'b0, resetn = 1'b0, ce, psel, penable, pwrite, reloadN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, drpCtrl, seed, d0;
  logic        pready, pslverr, flashCsN, flashImageSel, cclkOut;
  logic        userActive, loadDone, loadFail, fallbackUsed;
  logic [2:0]  modePins;
  logic [4:0]  busW;
  logic [15:0] flashData;
  logic [KEY_W-1:0] batteryKey, fuseKey;
  note_s       q[$];
  int          errors = 0;
  int          compares = 0;
  always #2 clk = ~clk;
  initial
  begin
    #3;
    forever
    begin
      #7 cfgClk = ~cfgClk;
      #8 cfgClk = ~cfgClk;
    end
  end
  // x1 needs about 260 cycles from select to the sync word
  bitstream_loader #(.TIMEOUT_CYCLES(400)) u_dut (.clk, .resetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reloadN, .modePins, .cfgClk,
    .flashData, .flashCsN, .flashImageSel, .cclkOut, .batteryKey, .fuseKey, .userActive,
    .loadDone, .loadFail, .fallbackUsed, .drpCtrl);
  flash_model u_flash (.cfgClk, .flashCsN, .busW, .flashData);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] foldKey(input logic [KEY_W-1:0] k);
    logic [31:0] f;
    f = 32'h0;
    for (int i = 0; i < KEY_W / 32; i++)
      f = {f[30:0], f[31]} ^ k[i*32 +: 32];
    return f;
  endfunction : foldKey
  function automatic logic pin(input int s);
    return s ? loadFail : flashCsN;
  endfunction : pin
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    n = 0;
    q.push_back('{d, m, e});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    check("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic waitPin(input int s, input logic v);
    int n;
    n = 0;
    while (pin(s) !== v && n < 8000)
    begin
      @(posedge clk);
      n++;
    end
    check("pin wait", {31'h0, pin(s)}, {31'h0, v});
  endtask : waitPin
  task automatic pulse();
    reloadN <= 1'b0;
    repeat (80) @(posedge clk);
    check("flashCsN", {31'h0, flashCsN}, 32'h1);
    reloadN <= 1'b1;
    @(posedge clk);
  endtask : pulse
  task automatic status(input logic [2:0] md, input logic [2:0] wc);
    repeat (10) @(posedge clk);
    apb(1'b0, ADDR_STATUS, {17'h0, md, 1'b0, wc, 1'b0, 3'(ST_FAIL), 4'h6}, 32'h7777, 1'b0);
  endtask : status
  task automatic end_sim();
    if (q.size() != 0)
    begin
      errors++;
      $display("Error queue expected 0 seen %0d", q.size());
    end
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // answers are checked in order of issue, one per access cycle
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      note_s n;
      n = q.pop_front();
      check("prdata", prdata & n.mask, n.data & n.mask);
      check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
    end
  end
  initial
  begin
    #100000;
    errors++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end
  initial
  begin
    logic [31:0] sw [4];
    {ce, psel, penable, pwrite, paddr, pwdata} = '0;
    ce         = 1'b1;
    reloadN    = 1'b1;
    modePins   = MODE_SERIAL;
    busW       = 5'd1;
    seed       = 32'h63c1;
    batteryKey = {8{rnd()}};
    fuseKey    = {8{rnd()}};
    repeat (16) @(posedge clk);
    check("reset pins", {26'h0, flashCsN, flashImageSel, cclkOut, userActive, loadDone,
          loadFail}, 32'h20);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_CTRL, {27'h0, CTRL_RST}, 32'h1f, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 12'h060, rnd(), 32'h0, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      sw[0] = rnd();
      if (k == 0)
        d0 = sw[0];
      apb(1'b1, ADDR_DRP + 12'(4 * k), sw[0], 32'h0, 1'b0);
      apb(1'b0, ADDR_DRP + 12'(4 * k), sw[0], 32'hffffffff, 1'b0);
    end
    check("drpCtrl", drpCtrl, d0);
    // power-up load first, then a reload per width; tags never match
    for (int i = 0; i < 5; i++)
    begin
      busW     <= 5'(1 << i);
      modePins <= (i < 3) ? MODE_SERIAL : MODE_PARALLEL;
      if (i > 0)
        pulse();
      waitPin(0, 1'b0);
      waitPin(0, 1'b1);
      waitPin(1, 1'b1);
      status((i < 3) ? MODE_SERIAL : MODE_PARALLEL, 3'(i));
    end
    modePins <= MODE_SLAVE;
    pulse();
    // the loader takes words only a few cycles after the pin release
    repeat (4) @(posedge clk);
    sw = '{SYNC_WORD, 32'h0000_0001, rnd(), rnd()};
    foreach (sw[k])
    begin
      if (k == 2)
        apb(1'b0, ADDR_STATUS, {25'h0, 3'(ST_DATA), 4'h0}, 32'h70, 1'b0);
      apb(1'b1, ADDR_SLAVE, sw[k], 32'h0, 1'b0);
    end
    waitPin(1, 1'b1);
    status(MODE_SLAVE, WIDTH_SLAVE);
    check("flashCsN", {31'h0, flashCsN}, 32'h1);
    // the one data word landed at base 0, decrypted with the battery key
    apb(1'b1, ADDR_RBADDR, 32'hc0, 32'h0, 1'b0);
    apb(1'b0, ADDR_RBDATA, sw[2] ^ foldKey(batteryKey), 32'hffffffff, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h9, 32'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h8, 32'h1, 1'b0);
    waitPin(1, 1'b0);
    end_sim();
  end
endmodule : tb_top
